// >>> core/wake_regs_pkg.sv
package wake_regs_pkg;
   // serial frame: first byte {address[6:0], write}, second byte data
   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;
   localparam int SYNC_STAGES = 3;
   localparam logic [4:0] ADDR_BITS = 5'h08;
   localparam logic [4:0] FRAME_BITS = 5'h10;
   localparam logic [4:0] CNT_ONE = 5'h01;
   localparam logic [4:0] CNT_ZERO = 5'h00;

   localparam logic [ADDR_W-1:0] OFF_QSTAT = 7'h2F;
   localparam logic [ADDR_W-1:0] OFF_ID_HIGH = 7'h30;
   localparam logic [ADDR_W-1:0] OFF_ID_MID = 7'h31;
   localparam logic [ADDR_W-1:0] OFF_ID_FMT = 7'h32;
   localparam logic [ADDR_W-1:0] OFF_ID_LOW = 7'h33;
   localparam logic [ADDR_W-1:0] OFF_MASK_TOP = 7'h34;
   localparam logic [ADDR_W-1:0] OFF_MASK_MID = 7'h35;
   localparam logic [ADDR_W-1:0] OFF_MASK_LOW = 7'h36;

   localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
   localparam logic [DATA_W-1:0] WMASK_FULL = 8'hFF;
   localparam logic [DATA_W-1:0] WMASK_ID_LOW = 8'hFC;
   localparam logic [DATA_W-1:0] WMASK_MASK_TOP = 8'h03;

   // watchdog question status layout
   localparam int RSVD_BIT = 7;
   localparam int ERR_BIT = 6;
   localparam int CNT_MSB = 5;
   localparam int CNT_LSB = 4;
   localparam int Q_MSB = 3;
   localparam int Q_LSB = 0;
   localparam logic [1:0] CNT_WD_ON = 2'h3;
   localparam logic [3:0] Q_WD_ON = 4'hC;

   // identifier format and base high layout
   localparam int EXT10_MSB = 7;
   localparam int EXT10_LSB = 6;
   localparam int FMT_BIT = 5;
   localparam int BASEH_MSB = 4;
   localparam int BASEH_LSB = 0;
   // identifier base low and mask top layout
   localparam int BASEL_MSB = 7;
   localparam int BASEL_LSB = 2;
   localparam int MTOP_MSB = 1;
   localparam int MTOP_LSB = 0;
endpackage

// >>> core/serial_port.sv
`timescale 1ns/1ps
`default_nettype none
module serial_port (
   input wire logic clk,
   input wire logic rst,
   input wire logic sclk_pin,
   input wire logic cs_n_pin,
   input wire logic sdi_pin,
   input wire logic [wake_regs_pkg::DATA_W-1:0] rd_data,
   output logic wr_strobe,
   output logic [wake_regs_pkg::ADDR_W-1:0] reg_addr,
   output logic [wake_regs_pkg::DATA_W-1:0] wr_data,
   output logic sdo,
   output logic sdo_oe_n
);
   import wake_regs_pkg::*;

   logic [SYNC_STAGES-1:0] sclk_sync_reg, sclk_sync_next;
   logic [SYNC_STAGES-1:0] cs_sync_reg, cs_sync_next;
   logic [SYNC_STAGES-1:0] sdi_sync_reg, sdi_sync_next;
   logic sclk_lvl_reg, sclk_lvl_next;
   logic cs_n_lvl_reg, cs_n_lvl_next;
   logic sdi_lvl_reg, sdi_lvl_next;
   logic [4:0] cnt_reg, cnt_next;
   logic [DATA_W-1:0] shift_reg, shift_next;
   logic [DATA_W-1:0] out_reg, out_next;
   logic [DATA_W-1:0] data_reg, data_next;
   logic [ADDR_W-1:0] addr_reg, addr_next;
   logic write_reg, write_next;
   logic load_reg, load_next;
   logic wr_reg, wr_next;
   logic sdo_reg, sdo_next;
   logic oe_n_reg, oe_n_next;
   logic rise, fall;

   // a level counts only once the second and third stages agree
   function automatic logic settle(input logic [SYNC_STAGES-1:0] s,
                                   input logic prev);
      return (s[1] == s[2]) ? s[2] : prev;
   endfunction

   always_comb begin
      sclk_sync_next = {sclk_sync_reg[1:0], sclk_pin};
      cs_sync_next = {cs_sync_reg[1:0], cs_n_pin};
      sdi_sync_next = {sdi_sync_reg[1:0], sdi_pin};
      sclk_lvl_next = settle(sclk_sync_reg, sclk_lvl_reg);
      cs_n_lvl_next = settle(cs_sync_reg, cs_n_lvl_reg);
      sdi_lvl_next = settle(sdi_sync_reg, sdi_lvl_reg);
      rise = sclk_lvl_next & ~sclk_lvl_reg;
      fall = ~sclk_lvl_next & sclk_lvl_reg;
      cnt_next = cnt_reg;
      shift_next = shift_reg;
      out_next = out_reg;
      data_next = data_reg;
      addr_next = addr_reg;
      write_next = write_reg;
      load_next = 1'b0;
      wr_next = 1'b0;
      sdo_next = sdo_reg;
      oe_n_next = oe_n_reg;
      if (cs_n_lvl_reg) begin
         cnt_next = CNT_ZERO;
         sdo_next = 1'b0;
         oe_n_next = 1'b1;
      end else begin
         // read data is taken one cycle after the address settles
         if (load_reg) begin
            out_next = rd_data;
         end
         if (rise && cnt_reg < FRAME_BITS) begin
            shift_next = {shift_reg[DATA_W-2:0], sdi_lvl_next};
            cnt_next = cnt_reg + CNT_ONE;
            if (cnt_reg == ADDR_BITS - CNT_ONE) begin
               addr_next = shift_reg[ADDR_W-1:0];
               write_next = sdi_lvl_next;
               load_next = 1'b1;
            end
            // a frame cut short never reaches this point: no write
            if (cnt_reg == FRAME_BITS - CNT_ONE && write_reg) begin
               wr_next = 1'b1;
               data_next = {shift_reg[DATA_W-2:0], sdi_lvl_next};
            end
         end
         if (fall && !write_reg && cnt_reg >= ADDR_BITS &&
             cnt_reg < FRAME_BITS) begin
            sdo_next = out_reg[DATA_W-1];
            out_next = {out_reg[DATA_W-2:0], 1'b0};
            oe_n_next = 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sclk_sync_reg <= '0;
         cs_sync_reg <= '1;
         sdi_sync_reg <= '0;
         sclk_lvl_reg <= 1'b0;
         cs_n_lvl_reg <= 1'b1;
         sdi_lvl_reg <= 1'b0;
         cnt_reg <= CNT_ZERO;
         shift_reg <= RST_BYTE;
         out_reg <= RST_BYTE;
         data_reg <= RST_BYTE;
         addr_reg <= '0;
         write_reg <= 1'b0;
         load_reg <= 1'b0;
         wr_reg <= 1'b0;
         sdo_reg <= 1'b0;
         oe_n_reg <= 1'b1;
      end else begin
         sclk_sync_reg <= sclk_sync_next;
         cs_sync_reg <= cs_sync_next;
         sdi_sync_reg <= sdi_sync_next;
         sclk_lvl_reg <= sclk_lvl_next;
         cs_n_lvl_reg <= cs_n_lvl_next;
         sdi_lvl_reg <= sdi_lvl_next;
         cnt_reg <= cnt_next;
         shift_reg <= shift_next;
         out_reg <= out_next;
         data_reg <= data_next;
         addr_reg <= addr_next;
         write_reg <= write_next;
         load_reg <= load_next;
         wr_reg <= wr_next;
         sdo_reg <= sdo_next;
         oe_n_reg <= oe_n_next;
      end
   end

   assign wr_strobe = wr_reg;
   assign reg_addr = addr_reg;
   assign wr_data = data_reg;
   assign sdo = sdo_reg;
   assign sdo_oe_n = oe_n_reg;
endmodule // serial_port
`default_nettype wire

// >>> core/wake_frame_id_mask_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1 - Status bit 6 is a sticky answer error flag, cleared by writing one, unchanged by zero, reset to zero.
// R2 - Status bits 5-4 are read-only answer count and read 3 while the watchdog is enabled.
// R3 - Status bits 3-0 are read-only current question and read C while the watchdog is enabled.
// R4 - Byte 30h is read-write, resets to zero and drives extended identifier bits 17:10.
// R5 - Byte 31h is read-write, resets to zero and drives extended identifier bits 9:2.
// R6 - Bit 5 of byte 32h selects standard (0) or extended (1) identifier format, reset zero.
// R7 - Byte 32h bits 7-6 hold extended bits 1:0 and bits 4-0 hold base bits 10:6, read-write, reset zero.
// R8 - Byte 33h bits 7-2 hold base bits 5:0 read-write, bits 1-0 read zero.
// R9 - Byte 34h bits 1-0 hold mask bits 17:16 read-write, upper bits read zero.
// R10 - Byte 35h is read-write, resets to zero and holds mask bits 15:8.
// R11 - Status bit 7 at 2Fh is reserved and reads zero.
// R12 - Byte 36h is read-write, resets to zero and holds mask bits 7:0.
// R13 - Writes to read-only or reserved positions are ignored and those read their fixed values.
// R14 - The answer checker sets the error flag and a set beats a same-cycle clear.
module wake_frame_id_mask_regs (
   input wire logic CLOCK,
   input wire logic SYS_RST,
   input wire logic SPI_SCLK,
   input wire logic SPI_CS_N,
   input wire logic SPI_SDI,
   output logic SPI_SDO,
   output logic SPI_SDO_OE_N,
   input wire logic WD_ENABLE,
   input wire logic [wake_regs_pkg::Q_MSB:wake_regs_pkg::Q_LSB] CURRENT_QUESTION,
   input wire logic [1:0] ANSWER_COUNT,
   input wire logic ANSWER_ERROR_EVENT,
   output logic ANSWER_ERROR_FLAG,
   output logic [7:0] EXT_IDENTIFIER_17_10,
   output logic [7:0] EXT_IDENTIFIER_9_2,
   output logic [1:0] EXT_IDENTIFIER_1_0,
   output logic ID_FORMAT_EXTENDED,
   output logic [4:0] BASE_IDENTIFIER_HIGH,
   output logic [5:0] BASE_IDENTIFIER_LOW,
   output logic [1:0] EXT_MASK_17_16,
   output logic [7:0] EXT_MASK_15_8,
   output logic [7:0] EXT_MASK_7_0
);
   import wake_regs_pkg::*;

   logic wr_strobe;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] wr_data;
   logic [DATA_W-1:0] rd_data;
   logic [DATA_W-1:0] status_view;

   logic err_reg, err_next;
   logic [DATA_W-1:0] wake_ext_id_high_byte_reg, wake_ext_id_high_byte_next;
   logic [DATA_W-1:0] wake_ext_id_mid_byte_reg, wake_ext_id_mid_byte_next;
   logic [DATA_W-1:0] wake_id_format_and_base_high_reg;
   logic [DATA_W-1:0] wake_id_format_and_base_high_next;
   logic [DATA_W-1:0] wake_id_base_low_reg, wake_id_base_low_next;
   logic [DATA_W-1:0] wake_ext_mask_top_bits_reg, wake_ext_mask_top_bits_next;
   logic [DATA_W-1:0] wake_ext_mask_mid_byte_reg, wake_ext_mask_mid_byte_next;
   logic [DATA_W-1:0] wake_ext_mask_low_byte_reg, wake_ext_mask_low_byte_next;

   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [ADDR_W-1:0] off);
      return a == off;
   endfunction

   serial_port u_port (
      .clk(CLOCK),
      .rst(SYS_RST),
      .sclk_pin(SPI_SCLK),
      .cs_n_pin(SPI_CS_N),
      .sdi_pin(SPI_SDI),
      .rd_data(rd_data),
      .wr_strobe(wr_strobe),
      .reg_addr(reg_addr),
      .wr_data(wr_data),
      .sdo(SPI_SDO),
      .sdo_oe_n(SPI_SDO_OE_N)
   );

   // status byte is assembled live; only the error flag is stored here
   always_comb begin
      status_view = RST_BYTE;
      status_view[RSVD_BIT] = 1'b0; // see R11
      status_view[ERR_BIT] = err_reg;
      // an enabled watchdog forces the documented pattern, see R2 R3
      status_view[CNT_MSB:CNT_LSB] = WD_ENABLE ? CNT_WD_ON : ANSWER_COUNT;
      status_view[Q_MSB:Q_LSB] = WD_ENABLE ? Q_WD_ON : CURRENT_QUESTION;
   end

   // unmapped addresses read as zero
   always_comb begin
      if (hit(reg_addr, OFF_QSTAT)) begin
         rd_data = status_view;
      end else if (hit(reg_addr, OFF_ID_HIGH)) begin
         rd_data = wake_ext_id_high_byte_reg;
      end else if (hit(reg_addr, OFF_ID_MID)) begin
         rd_data = wake_ext_id_mid_byte_reg;
      end else if (hit(reg_addr, OFF_ID_FMT)) begin
         rd_data = wake_id_format_and_base_high_reg;
      end else if (hit(reg_addr, OFF_ID_LOW)) begin
         rd_data = wake_id_base_low_reg;
      end else if (hit(reg_addr, OFF_MASK_TOP)) begin
         rd_data = wake_ext_mask_top_bits_reg;
      end else if (hit(reg_addr, OFF_MASK_MID)) begin
         rd_data = wake_ext_mask_mid_byte_reg;
      end else if (hit(reg_addr, OFF_MASK_LOW)) begin
         rd_data = wake_ext_mask_low_byte_reg;
      end else begin
         rd_data = RST_BYTE;
      end
   end

   always_comb begin
      err_next = err_reg;
      wake_ext_id_high_byte_next = wake_ext_id_high_byte_reg;
      wake_ext_id_mid_byte_next = wake_ext_id_mid_byte_reg;
      wake_id_format_and_base_high_next = wake_id_format_and_base_high_reg;
      wake_id_base_low_next = wake_id_base_low_reg;
      wake_ext_mask_top_bits_next = wake_ext_mask_top_bits_reg;
      wake_ext_mask_mid_byte_next = wake_ext_mask_mid_byte_reg;
      wake_ext_mask_low_byte_next = wake_ext_mask_low_byte_reg;
      if (wr_strobe) begin
         if (hit(reg_addr, OFF_QSTAT)) begin
            if (wr_data[ERR_BIT]) begin
               err_next = 1'b0; // see R1
            end
         end else if (hit(reg_addr, OFF_ID_HIGH)) begin
            wake_ext_id_high_byte_next = wr_data & WMASK_FULL; // see R4
         end else if (hit(reg_addr, OFF_ID_MID)) begin
            wake_ext_id_mid_byte_next = wr_data & WMASK_FULL; // see R5
         end else if (hit(reg_addr, OFF_ID_FMT)) begin
            // see R6 R7
            wake_id_format_and_base_high_next = wr_data & WMASK_FULL;
         end else if (hit(reg_addr, OFF_ID_LOW)) begin
            wake_id_base_low_next = wr_data & WMASK_ID_LOW; // see R8 R13
         end else if (hit(reg_addr, OFF_MASK_TOP)) begin
            wake_ext_mask_top_bits_next = wr_data & WMASK_MASK_TOP; // see R9
         end else if (hit(reg_addr, OFF_MASK_MID)) begin
            wake_ext_mask_mid_byte_next = wr_data & WMASK_FULL; // see R10
         end else if (hit(reg_addr, OFF_MASK_LOW)) begin
            wake_ext_mask_low_byte_next = wr_data & WMASK_FULL; // see R12
         end
      end
      // set after clear so a simultaneous error is never lost
      if (ANSWER_ERROR_EVENT) begin
         err_next = 1'b1; // see R14
      end
   end

   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         err_reg <= 1'b0;
         wake_ext_id_high_byte_reg <= RST_BYTE;
         wake_ext_id_mid_byte_reg <= RST_BYTE;
         wake_id_format_and_base_high_reg <= RST_BYTE;
         wake_id_base_low_reg <= RST_BYTE;
         wake_ext_mask_top_bits_reg <= RST_BYTE;
         wake_ext_mask_mid_byte_reg <= RST_BYTE;
         wake_ext_mask_low_byte_reg <= RST_BYTE;
      end else begin
         err_reg <= err_next;
         wake_ext_id_high_byte_reg <= wake_ext_id_high_byte_next;
         wake_ext_id_mid_byte_reg <= wake_ext_id_mid_byte_next;
         wake_id_format_and_base_high_reg <= wake_id_format_and_base_high_next;
         wake_id_base_low_reg <= wake_id_base_low_next;
         wake_ext_mask_top_bits_reg <= wake_ext_mask_top_bits_next;
         wake_ext_mask_mid_byte_reg <= wake_ext_mask_mid_byte_next;
         wake_ext_mask_low_byte_reg <= wake_ext_mask_low_byte_next;
      end
   end

   assign ANSWER_ERROR_FLAG = err_reg;
   assign EXT_IDENTIFIER_17_10 = wake_ext_id_high_byte_reg;
   assign EXT_IDENTIFIER_9_2 = wake_ext_id_mid_byte_reg;
   assign EXT_IDENTIFIER_1_0 =
      wake_id_format_and_base_high_reg[EXT10_MSB:EXT10_LSB];
   assign ID_FORMAT_EXTENDED = wake_id_format_and_base_high_reg[FMT_BIT];
   assign BASE_IDENTIFIER_HIGH =
      wake_id_format_and_base_high_reg[BASEH_MSB:BASEH_LSB];
   assign BASE_IDENTIFIER_LOW = wake_id_base_low_reg[BASEL_MSB:BASEL_LSB];
   assign EXT_MASK_17_16 = wake_ext_mask_top_bits_reg[MTOP_MSB:MTOP_LSB];
   assign EXT_MASK_15_8 = wake_ext_mask_mid_byte_reg;
   assign EXT_MASK_7_0 = wake_ext_mask_low_byte_reg;

   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (SYS_RST);

   logic clr_hit;
   assign clr_hit = wr_strobe && hit(reg_addr, OFF_QSTAT) && wr_data[ERR_BIT];

   a_err_w1c_clear: assert property (clr_hit && !ANSWER_ERROR_EVENT |=> // see R1
      !ANSWER_ERROR_FLAG) else $error("error flag not cleared");
   a_err_sticky_hold: assert property (!clr_hit && !ANSWER_ERROR_EVENT |=> // see R1
      $stable(ANSWER_ERROR_FLAG)) else $error("error flag moved");
   a_err_set_wins: assert property (ANSWER_ERROR_EVENT |=> // see R14
      ANSWER_ERROR_FLAG) else $error("error event lost");
   a_count_wd_on: assert property (WD_ENABLE |-> // see R2
      status_view[CNT_MSB:CNT_LSB] == CNT_WD_ON) else $error("count not 3");
   a_question_wd_on: assert property (WD_ENABLE |-> // see R3
      status_view[Q_MSB:Q_LSB] == Q_WD_ON) else $error("question not C");
   a_status_follow: assert property (!WD_ENABLE |-> // see R3
      status_view[Q_MSB:Q_LSB] == CURRENT_QUESTION)
      else $error("question not passed");
   a_status_rsvd_zero: assert property (!status_view[RSVD_BIT]) // see R11
      else $error("status bit 7 set");
   a_id_high_write: assert property (wr_strobe && // see R4
      hit(reg_addr, OFF_ID_HIGH) |=> EXT_IDENTIFIER_17_10 == $past(wr_data))
      else $error("id high not written");
   a_format_write: assert property (wr_strobe && // see R6
      hit(reg_addr, OFF_ID_FMT) |=> ID_FORMAT_EXTENDED == $past(wr_data[FMT_BIT]))
      else $error("format bit not written");
   a_mask_low_write: assert property (wr_strobe && // see R12
      hit(reg_addr, OFF_MASK_LOW) |=> EXT_MASK_7_0 == $past(wr_data))
      else $error("mask low not written");
   a_rsvd_bits_zero: assert property ((wake_id_base_low_reg & ~WMASK_ID_LOW) == RST_BYTE && // see R13
      (wake_ext_mask_top_bits_reg & ~WMASK_MASK_TOP) == RST_BYTE)
      else $error("reserved bits set");

   c_err_set: cover property (ANSWER_ERROR_EVENT ##1 clr_hit ##1 !ANSWER_ERROR_FLAG);
   c_id_write: cover property (wr_strobe && hit(reg_addr, OFF_ID_FMT));
   c_mask_write: cover property (wr_strobe && hit(reg_addr, OFF_MASK_TOP));
endmodule // wake_frame_id_mask_regs
`default_nettype wire

// >>> sim/spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
   input wire logic clk,
   output logic sclk,
   output logic cs_n,
   output logic sdi,
   input wire logic sdo
);
   // each serial clock level lasts far longer than the input synchroniser
   localparam int HALF = 10;

   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      sdi = 1'b0;
   end

   task automatic half_wait();
      repeat (HALF) @(posedge clk);
      #1;
   endtask

   // mode 0, msb first: {addr, wr} then data; read data taken on rises 9-16
   task automatic xfer(input logic [6:0] addr, input logic wr,
                       input logic [7:0] data, output logic [7:0] seen);
      logic [15:0] frame;
      frame = {addr, wr, data};
      seen = 8'h00;
      @(posedge clk);
      #1;
      cs_n = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         sdi = frame[i];
         half_wait();
         sclk = 1'b1;
         if (i < 8) begin
            seen = {seen[6:0], sdo};
         end
         half_wait();
         sclk = 1'b0;
      end
      half_wait();
      cs_n = 1'b1;
      // a released line must not keep showing the last bit
      sdi = ~sdi;
      half_wait();
   endtask
endmodule // spi_host_model
`default_nettype wire

// >>> sim/wake_frame_id_mask_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module wake_frame_id_mask_regs_bench;
   import wake_regs_pkg::*;
   localparam int CEILING = 60000;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic sclk, cs_n, sdi, sdo;
   logic wd_en = 1'b0;
   logic err_evt = 1'b0;
   logic [3:0] question = 4'h0;
   logic [1:0] count = 2'h0;
   logic flag, fmt;
   logic [7:0] id_17_10, id_9_2, mask_15_8, mask_7_0;
   logic [1:0] id_1_0, mask_17_16;
   logic [4:0] base_hi;
   logic [5:0] base_lo;
   int fail_count = 0;
   int samples_checked = 0;
   int cycles = 0;
   logic [6:0] addrs [7] = '{OFF_ID_HIGH, OFF_ID_MID, OFF_ID_FMT, OFF_ID_LOW,
                             OFF_MASK_TOP, OFF_MASK_MID, OFF_MASK_LOW};
   logic [7:0] wmask [7] = '{WMASK_FULL, WMASK_FULL, WMASK_FULL, WMASK_ID_LOW,
                             WMASK_MASK_TOP, WMASK_FULL, WMASK_FULL};

   always #5 clk = ~clk;

   spi_host_model host_u (.clk(clk), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
                          .sdo(sdo));

   wake_frame_id_mask_regs dut_u (.CLOCK(clk), .SYS_RST(rst),
      .SPI_SCLK(sclk), .SPI_CS_N(cs_n), .SPI_SDI(sdi), .SPI_SDO(sdo),
      .SPI_SDO_OE_N(), .WD_ENABLE(wd_en), .CURRENT_QUESTION(question),
      .ANSWER_COUNT(count), .ANSWER_ERROR_EVENT(err_evt),
      .ANSWER_ERROR_FLAG(flag), .EXT_IDENTIFIER_17_10(id_17_10),
      .EXT_IDENTIFIER_9_2(id_9_2), .EXT_IDENTIFIER_1_0(id_1_0),
      .ID_FORMAT_EXTENDED(fmt), .BASE_IDENTIFIER_HIGH(base_hi),
      .BASE_IDENTIFIER_LOW(base_lo), .EXT_MASK_17_16(mask_17_16),
      .EXT_MASK_15_8(mask_15_8), .EXT_MASK_7_0(mask_7_0));

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == CEILING) begin
         fail_count++;
         $display("[ERR] cycle limit expected below %0d seen %0d", CEILING,
                  cycles);
         end_of_test();
      end
   end

   task automatic chk(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] unused;
      host_u.xfer(a, 1'b1, d, unused);
   endtask

   task automatic rd_chk(input string what, input logic [6:0] a,
                         input logic [7:0] exp);
      logic [7:0] got;
      host_u.xfer(a, 1'b0, 8'h00, got);
      chk(what, exp, got);
   endtask

   // the filter-side ports rebuilt into the byte layout of each offset
   function automatic logic [7:0] port_view(input logic [6:0] a);
      case (a)
         OFF_ID_HIGH: return id_17_10;
         OFF_ID_MID: return id_9_2;
         OFF_ID_FMT: return {id_1_0, fmt, base_hi};
         OFF_ID_LOW: return {base_lo, 2'h0};
         OFF_MASK_TOP: return {6'h00, mask_17_16};
         OFF_MASK_MID: return mask_15_8;
         default: return mask_7_0;
      endcase
   endfunction

   task automatic do_reset();
      @(posedge clk);
      #1;
      rst = 1'b1;
      repeat (4) @(posedge clk);
      #1;
      rst = 1'b0;
      repeat (4) @(posedge clk);
   endtask

   task automatic pulse_err();
      @(posedge clk);
      #1;
      err_evt = 1'b1;
      @(posedge clk);
      #1;
      err_evt = 1'b0;
   endtask

   task automatic t_reset_values();
      for (int i = 0; i < 7; i++) begin
         rd_chk("reset read", addrs[i], RST_BYTE);
         chk("reset port", RST_BYTE, port_view(addrs[i]));
      end
      rd_chk("status reset", OFF_QSTAT, RST_BYTE);
   endtask

   // all bytes written before any is read, so aliasing shows up
   task automatic t_read_write(input logic [7:0] pat);
      for (int i = 0; i < 7; i++) begin
         wr(addrs[i], pat);
      end
      for (int i = 0; i < 7; i++) begin
         chk("port", pat & wmask[i], port_view(addrs[i]));
         rd_chk("readback", addrs[i], pat & wmask[i]);
      end
   endtask

   task automatic t_status();
      question = 4'h5;
      count = 2'h1;
      rd_chk("status off", OFF_QSTAT, {2'h0, 2'h1, 4'h5});
      wd_en = 1'b1;
      rd_chk("status on", OFF_QSTAT, {2'h0, CNT_WD_ON, Q_WD_ON});
      wr(OFF_QSTAT, 8'hFF);
      rd_chk("status ro", OFF_QSTAT, {2'h0, CNT_WD_ON, Q_WD_ON});
   endtask

   task automatic t_error_flag();
      pulse_err();
      chk("flag set", 8'h01, {7'h00, flag});
      rd_chk("flag read", OFF_QSTAT, {2'h1, CNT_WD_ON, Q_WD_ON});
      wr(OFF_QSTAT, 8'hBF);
      chk("flag zero write", 8'h01, {7'h00, flag});
      wr(OFF_QSTAT, 8'h40);
      chk("flag cleared", 8'h00, {7'h00, flag});
      // event held through the clearing write: the set must win
      @(posedge clk);
      #1;
      err_evt = 1'b1;
      wr(OFF_QSTAT, 8'h40);
      chk("set beats clear", 8'h01, {7'h00, flag});
      @(posedge clk);
      #1;
      err_evt = 1'b0;
      wr(OFF_QSTAT, 8'h40);
      chk("flag cleared again", 8'h00, {7'h00, flag});
   endtask

   task automatic t_unmapped();
      wr(7'h37, 8'hFF);
      rd_chk("unmapped", 7'h37, 8'h00);
      rd_chk("neighbour", OFF_MASK_LOW, 8'h5A);
   endtask

   task automatic t_midrun_reset();
      pulse_err();
      do_reset();
      chk("flag after reset", 8'h00, {7'h00, flag});
      chk("mask after reset", RST_BYTE, port_view(OFF_MASK_LOW));
   endtask

   initial begin
      do_reset();
      t_reset_values();
      t_read_write(8'hA5);
      t_read_write(8'h5A);
      t_status();
      t_error_flag();
      t_unmapped();
      t_midrun_reset();
      end_of_test();
   end
endmodule // wake_frame_id_mask_regs_bench
`default_nettype wire
